// File: pkg/cccr_pkg.sv
//------------------------------------------------------------------------------
// Function
// [R1] preview line width is horizontal size field plus one, at most 640 in RGB
// [R2] decimation factor is eight bits; values of 16 or below do no decimation
// [R3] first four YCrCb-to-RGB coefficients: unsigned, step 1/128, up to 1.99
// [R4] fifth YCrCb-to-RGB coefficient: unsigned, step 1/128, up to 3.99, 9 bits
// [R5] luminance offset flag set applies offset 128, clear applies none
// [R6] red and blue chrominance offset flags each apply offset 16 when set
// [R7] RGB-to-YCrCb coefficients 0..2 use steps 1/256, 1/128, 1/512
// [R8] red component offset flag adds 16 when set, nothing when clear
// [R9] RGB-to-YCrCb coefficients 3..5 use steps 1/128, 1/256, 1/512
// [R10] green component offset flag adds 128 when set, nothing when clear
// [R11] RGB-to-YCrCb coefficients 6..8 use steps 1/512, 1/256, 1/128
// [R12] blue component offset flag adds 128 when set, nothing when clear
// [R13] enable command requests enable; software polls enable status bit
// [R14] disable command requests disable, ignored with enable; done flag reports
// [R15] soft reset command starts reset; software polls the reset-done flag
// [R16] codec command captures one frame; ignored while codec pending is set
// [R17] status bit 0 reads 0 when enabled and 1 when disabled
// [R18] disable-done flag at bit 1 set on completion, cleared by status read
// [R19] reset-done flag at bit 2 set on completion, cleared by status read
// [R20] codec pending at bit 8 set while accepted request waits for next frame
// [R21] vsync flag at bit 10 set when a vertical sync seen since last read
// [R22] software must start the sensor pixel clock before programming the unit
// [R23] zero bits written to control are ignored; reserved bits read zero
// [R24] vsync flag clears on status read
//------------------------------------------------------------------------------
package cccr_pkg;

   //---------------------------------------------------------------------------
   // register byte offsets
   //---------------------------------------------------------------------------
   localparam logic [7:0] OFS_PSIZE = 8'h08;
   localparam logic [7:0] OFS_PDECIM = 8'h0C;
   localparam logic [7:0] OFS_Y2R_A = 8'h10;
   localparam logic [7:0] OFS_Y2R_B = 8'h14;
   localparam logic [7:0] OFS_R2Y_A = 8'h18;
   localparam logic [7:0] OFS_R2Y_B = 8'h1C;
   localparam logic [7:0] OFS_R2Y_C = 8'h20;
   localparam logic [7:0] OFS_CMD = 8'h24;
   localparam logic [7:0] OFS_STATE = 8'h28;
   localparam logic [7:0] OFS_MODE = 8'h5C;

   //---------------------------------------------------------------------------
   // reset values and writable-bit masks
   //---------------------------------------------------------------------------
   localparam logic [31:0] RST_PSIZE = 32'h0000_0000;
   localparam logic [31:0] RST_PDECIM = 32'h0000_0010;
   localparam logic [31:0] RST_Y2R_A = 32'h6832_CC95;
   localparam logic [31:0] RST_Y2R_B = 32'h0000_7102;
   localparam logic [31:0] RST_R2Y_A = 32'h0132_4145;
   localparam logic [31:0] RST_R2Y_B = 32'h0124_5E38;
   localparam logic [31:0] RST_R2Y_C = 32'h0138_4A4B;
   localparam logic [31:0] RST_MODE = 32'h0000_0000;
   localparam logic [31:0] MSK_PSIZE = 32'h03FF_03FF;
   localparam logic [31:0] MSK_PDECIM = 32'h0000_00FF;
   localparam logic [31:0] MSK_Y2R_A = 32'hFFFF_FFFF;
   localparam logic [31:0] MSK_Y2R_B = 32'h0000_71FF;
   localparam logic [31:0] MSK_R2Y = 32'h01FF_FFFF;
   localparam logic [31:0] MSK_MODE = 32'h0000_0001;

   //---------------------------------------------------------------------------
   // field positions
   //---------------------------------------------------------------------------
   localparam int PSIZE_H_LSB = 16;
   localparam int PSIZE_H_W = 10;
   localparam int Y2R_YOFF_BIT = 12;
   localparam int Y2R_CROFF_BIT = 13;
   localparam int Y2R_CBOFF_BIT = 14;
   localparam int R2Y_OFF_BIT = 24;
   localparam int CMD_EN_BIT = 0;
   localparam int CMD_DIS_BIT = 1;
   localparam int CMD_RESET_DONE_FLAG_BIT = 2;
   localparam int CMD_CDC_BIT = 8;
   localparam int ST_DIS_BIT = 0;
   localparam int ST_DDONE_BIT = 1;
   localparam int ST_RDONE_BIT = 2;
   localparam int ST_CPND_BIT = 8;
   localparam int ST_VSYNC_BIT = 10;
   localparam int MODE_RGB_BIT = 0;

   //---------------------------------------------------------------------------
   // datapath values and timing
   //---------------------------------------------------------------------------
   localparam logic [10:0] RGB_MAX_WIDTH = 11'd640;
   localparam logic [7:0] DECIM_MIN = 8'd16;
   localparam logic [7:0] OFFSET_128 = 8'd128;
   localparam logic [7:0] OFFSET_16 = 8'd16;
   localparam int Y2R_FRAC_BITS = 7;
   localparam int CMD_CYCLES = 8;

   typedef enum logic [1:0] {
      CCCR_IDLE = 2'b00,
      CCCR_ENABLING = 2'b01,
      CCCR_DISABLING = 2'b10,
      CCCR_RESETTING = 2'b11
   } cccr_cmd_state_type;

endpackage : cccr_pkg

// File: rtl/cccr_regs.sv
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/1ps
module cccr_regs #(
   parameter int CMD_LAT = cccr_pkg::CMD_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sensor_vsync,
   output logic module_enabled,
   output logic codec_capture_active,
   output logic [10:0] preview_line_width,
   output logic [7:0] preview_decim_factor,
   output logic preview_decim_active,
   output logic [7:0] y2r_c0,
   output logic [7:0] y2r_c1,
   output logic [7:0] y2r_c2,
   output logic [7:0] y2r_c3,
   output logic [8:0] y2r_c4,
   output logic [7:0] y2r_y_offset,
   output logic [7:0] y2r_cr_offset,
   output logic [7:0] y2r_cb_offset,
   output logic [7:0] r2y_c0,
   output logic [7:0] r2y_c1,
   output logic [7:0] r2y_c2,
   output logic [7:0] r2y_c3,
   output logic [7:0] r2y_c4,
   output logic [7:0] r2y_c5,
   output logic [7:0] r2y_c6,
   output logic [7:0] r2y_c7,
   output logic [7:0] r2y_c8,
   output logic [7:0] r2y_r_offset,
   output logic [7:0] r2y_g_offset,
   output logic [7:0] r2y_b_offset
);

   if (CMD_LAT < 1 || CMD_LAT > 255) begin : g_lat_chk
      $error("CMD_LAT must be 1..255");
   end

   //---------------------------------------------------------------------------
   // bus decode
   //---------------------------------------------------------------------------
   // zero wait states
   wire logic acc = psel & penable & clk_en;
   wire logic wr = acc & pwrite;
   wire logic rd = acc & ~pwrite;
   wire logic hit_psize = (paddr == cccr_pkg::OFS_PSIZE);
   wire logic hit_pdecim = (paddr == cccr_pkg::OFS_PDECIM);
   wire logic hit_y2r_a = (paddr == cccr_pkg::OFS_Y2R_A);
   wire logic hit_y2r_b = (paddr == cccr_pkg::OFS_Y2R_B);
   wire logic hit_r2y_a = (paddr == cccr_pkg::OFS_R2Y_A);
   wire logic hit_r2y_b = (paddr == cccr_pkg::OFS_R2Y_B);
   wire logic hit_r2y_c = (paddr == cccr_pkg::OFS_R2Y_C);
   wire logic hit_cmd = (paddr == cccr_pkg::OFS_CMD);
   wire logic hit_state = (paddr == cccr_pkg::OFS_STATE);
   wire logic hit_mode = (paddr == cccr_pkg::OFS_MODE);
   wire logic hit_any = hit_psize | hit_pdecim | hit_y2r_a | hit_y2r_b
                        | hit_r2y_a | hit_r2y_b | hit_r2y_c | hit_cmd
                        | hit_state | hit_mode;

   assign pready = 1'b1;
   assign pslverr = psel & penable & ~hit_any;

   //---------------------------------------------------------------------------
   // sensor vsync synchroniser and edge detect
   //---------------------------------------------------------------------------
   logic vs_meta_r;
   logic vs_sync_r;
   logic vs_prev_r;
   // vsync comes from the sensor domain, two flops before any use
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vs_meta_r <= 1'b0;
         vs_sync_r <= 1'b0;
         vs_prev_r <= 1'b0;
      end else if (clk_en) begin
         vs_meta_r <= sensor_vsync;
         vs_sync_r <= vs_meta_r;
         vs_prev_r <= vs_sync_r;
      end
   end
   wire logic vsync_edge = vs_sync_r & ~vs_prev_r;

   //---------------------------------------------------------------------------
   // command decode
   //---------------------------------------------------------------------------
   cccr_pkg::cccr_cmd_state_type st_r;
   cccr_pkg::cccr_cmd_state_type st_nxt;
   logic [7:0] cnt_r;
   logic [7:0] cnt_nxt;
   logic enabled_r;
   logic enabled_nxt;
   wire logic cmd_wr = wr & hit_cmd;
   // only bits written as one act; zero bits leave everything alone
   wire logic do_reset_done_flag = cmd_wr & pwdata[cccr_pkg::CMD_RESET_DONE_FLAG_BIT]; // R15 R23
   wire logic do_en = cmd_wr & pwdata[cccr_pkg::CMD_EN_BIT]; // R13 R23
   wire logic do_dis = cmd_wr & pwdata[cccr_pkg::CMD_DIS_BIT]
                       & ~pwdata[cccr_pkg::CMD_EN_BIT]; // R14
   wire logic do_cdc = cmd_wr & pwdata[cccr_pkg::CMD_CDC_BIT];
   wire logic cnt_done = (cnt_r == 8'd0);
   wire logic fin_dis = (st_r == cccr_pkg::CCCR_DISABLING) & cnt_done;
   wire logic fin_rst = (st_r == cccr_pkg::CCCR_RESETTING) & cnt_done;
   // soft reset returns the configuration to its reset values on completion
   wire logic cfg_reset = fin_rst & clk_en;

   //---------------------------------------------------------------------------
   // command sequencer; a command arriving while another runs is dropped,
   // so software must wait for the previous completion before the next
   //---------------------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      enabled_nxt = enabled_r;
      case (st_r)
         cccr_pkg::CCCR_IDLE: begin
            if (do_reset_done_flag) begin
               st_nxt = cccr_pkg::CCCR_RESETTING;
               cnt_nxt = 8'(CMD_LAT - 1);
            end else if (do_en) begin
               st_nxt = cccr_pkg::CCCR_ENABLING;
               cnt_nxt = 8'(CMD_LAT - 1);
            end else if (do_dis) begin
               st_nxt = cccr_pkg::CCCR_DISABLING;
               cnt_nxt = 8'(CMD_LAT - 1);
            end
         end
         cccr_pkg::CCCR_ENABLING: begin
            if (cnt_done) begin
               st_nxt = cccr_pkg::CCCR_IDLE;
               enabled_nxt = 1'b1; // R13
            end else begin
               cnt_nxt = cnt_r - 8'd1;
            end
         end
         cccr_pkg::CCCR_DISABLING: begin
            if (cnt_done) begin
               st_nxt = cccr_pkg::CCCR_IDLE;
               enabled_nxt = 1'b0; // R14
            end else begin
               cnt_nxt = cnt_r - 8'd1;
            end
         end
         cccr_pkg::CCCR_RESETTING: begin
            if (cnt_done) begin
               st_nxt = cccr_pkg::CCCR_IDLE;
               enabled_nxt = 1'b0; // R15
            end else begin
               cnt_nxt = cnt_r - 8'd1;
            end
         end
         default: begin
            st_nxt = cccr_pkg::CCCR_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= cccr_pkg::CCCR_IDLE;
         cnt_r <= 8'd0;
         enabled_r <= 1'b0;
      end else if (clk_en) begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         enabled_r <= enabled_nxt;
      end
   end

   //---------------------------------------------------------------------------
   // codec capture: request waits for the next vsync, then runs one frame
   //---------------------------------------------------------------------------
   logic cpnd_r;
   logic cact_r;
   wire logic cdc_take = do_cdc & ~cpnd_r & enabled_r & ~fin_rst; // R16
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cpnd_r <= 1'b0;
         cact_r <= 1'b0;
      end else if (clk_en) begin
         if (fin_rst || fin_dis) begin
            cpnd_r <= 1'b0;
            cact_r <= 1'b0;
         end else if (vsync_edge) begin
            cact_r <= cpnd_r; // R16 R20
            cpnd_r <= cdc_take;
         end else if (cdc_take) begin
            cpnd_r <= 1'b1; // R20
         end
      end
   end

   //---------------------------------------------------------------------------
   // sticky flags; a set in the same cycle as the clearing read wins
   //---------------------------------------------------------------------------
   logic ddone_r;
   logic rdone_r;
   logic vsf_r;
   wire logic st_rd = rd & hit_state;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ddone_r <= 1'b0;
         rdone_r <= 1'b0;
         vsf_r <= 1'b0;
      end else if (clk_en) begin
         // clear only what the loaded read data reported, so a flag set
         // on the setup edge is not lost
         ddone_r <= fin_dis | (ddone_r & ~(st_rd & prdata[1])); // R18
         rdone_r <= fin_rst | (rdone_r & ~(st_rd & prdata[2])); // R19
         vsf_r <= vsync_edge | (vsf_r & ~(st_rd & prdata[10])); // R21 R24
      end
   end

   //---------------------------------------------------------------------------
   // configuration registers
   //---------------------------------------------------------------------------
   logic [31:0] psize_r;
   logic [31:0] pdecim_r;
   logic [31:0] y2r_a_r;
   logic [31:0] y2r_b_r;
   logic [31:0] r2y_a_r;
   logic [31:0] r2y_b_r;
   logic [31:0] r2y_c_r;
   logic [31:0] mode_r;
   // reserved bits are masked on write so they always read back as zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         psize_r <= cccr_pkg::RST_PSIZE;
         pdecim_r <= cccr_pkg::RST_PDECIM;
         y2r_a_r <= cccr_pkg::RST_Y2R_A;
         y2r_b_r <= cccr_pkg::RST_Y2R_B;
         r2y_a_r <= cccr_pkg::RST_R2Y_A;
         r2y_b_r <= cccr_pkg::RST_R2Y_B;
         r2y_c_r <= cccr_pkg::RST_R2Y_C;
         mode_r <= cccr_pkg::RST_MODE;
      end else if (cfg_reset) begin
         psize_r <= cccr_pkg::RST_PSIZE;
         pdecim_r <= cccr_pkg::RST_PDECIM;
         y2r_a_r <= cccr_pkg::RST_Y2R_A;
         y2r_b_r <= cccr_pkg::RST_Y2R_B;
         r2y_a_r <= cccr_pkg::RST_R2Y_A;
         r2y_b_r <= cccr_pkg::RST_R2Y_B;
         r2y_c_r <= cccr_pkg::RST_R2Y_C;
         mode_r <= cccr_pkg::RST_MODE;
      end else if (wr) begin
         if (hit_psize) psize_r <= pwdata & cccr_pkg::MSK_PSIZE;
         if (hit_pdecim) pdecim_r <= pwdata & cccr_pkg::MSK_PDECIM; // R2
         if (hit_y2r_a) y2r_a_r <= pwdata & cccr_pkg::MSK_Y2R_A; // R3
         if (hit_y2r_b) y2r_b_r <= pwdata & cccr_pkg::MSK_Y2R_B; // R4
         if (hit_r2y_a) r2y_a_r <= pwdata & cccr_pkg::MSK_R2Y; // R7
         if (hit_r2y_b) r2y_b_r <= pwdata & cccr_pkg::MSK_R2Y; // R9
         if (hit_r2y_c) r2y_c_r <= pwdata & cccr_pkg::MSK_R2Y; // R11
         if (hit_mode) mode_r <= pwdata & cccr_pkg::MSK_MODE;
      end
   end

   //---------------------------------------------------------------------------
   // status word and read mux
   //---------------------------------------------------------------------------
   wire logic [31:0] state_word = {21'd0, vsf_r, 1'b0, cpnd_r, 5'd0,
                                   rdone_r, ddone_r, ~enabled_r}; // R17 R23
   wire logic [31:0] rd_mux =
      hit_psize ? psize_r :
      hit_pdecim ? pdecim_r :
      hit_y2r_a ? y2r_a_r :
      hit_y2r_b ? y2r_b_r :
      hit_r2y_a ? r2y_a_r :
      hit_r2y_b ? r2y_b_r :
      hit_r2y_c ? r2y_c_r :
      hit_state ? state_word :
      hit_mode ? mode_r : 32'h0000_0000; // command word reads zero

   // read data is registered in the setup cycle, valid in the access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (clk_en && psel && !penable && !pwrite) begin
         prdata <= rd_mux;
      end
   end

   //---------------------------------------------------------------------------
   // datapath-facing outputs
   //---------------------------------------------------------------------------
   wire logic [10:0] hsize_p1 = 11'(psize_r[cccr_pkg::PSIZE_H_LSB +:
                                            cccr_pkg::PSIZE_H_W]) + 11'd1;
   wire logic rgb_mode = mode_r[cccr_pkg::MODE_RGB_BIT];
   // RGB mode line width is clamped at 640
   wire logic [10:0] width_nxt =
      (rgb_mode && hsize_p1 > cccr_pkg::RGB_MAX_WIDTH) ?
      cccr_pkg::RGB_MAX_WIDTH : hsize_p1; // R1

   // registered so the datapath sees clean values
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         preview_line_width <= 11'd1;
         preview_decim_active <= 1'b0;
      end else if (clk_en) begin
         preview_line_width <= width_nxt; // R1
         preview_decim_active <= (pdecim_r[7:0] > cccr_pkg::DECIM_MIN); // R2
      end
   end

   assign module_enabled = enabled_r;
   assign codec_capture_active = cact_r;
   assign preview_decim_factor = pdecim_r[7:0]; // R2
   assign y2r_c0 = y2r_a_r[7:0]; // R3
   assign y2r_c1 = y2r_a_r[15:8];
   assign y2r_c2 = y2r_a_r[23:16];
   assign y2r_c3 = y2r_a_r[31:24];
   assign y2r_c4 = y2r_b_r[8:0]; // R4
   assign y2r_y_offset = y2r_b_r[cccr_pkg::Y2R_YOFF_BIT] ?
                         cccr_pkg::OFFSET_128 : 8'd0; // R5
   assign y2r_cr_offset = y2r_b_r[cccr_pkg::Y2R_CROFF_BIT] ?
                          cccr_pkg::OFFSET_16 : 8'd0; // R6
   assign y2r_cb_offset = y2r_b_r[cccr_pkg::Y2R_CBOFF_BIT] ?
                          cccr_pkg::OFFSET_16 : 8'd0; // R6
   assign r2y_c0 = r2y_a_r[7:0]; // R7
   assign r2y_c1 = r2y_a_r[15:8];
   assign r2y_c2 = r2y_a_r[23:16];
   assign r2y_c3 = r2y_b_r[7:0]; // R9
   assign r2y_c4 = r2y_b_r[15:8];
   assign r2y_c5 = r2y_b_r[23:16];
   assign r2y_c6 = r2y_c_r[7:0]; // R11
   assign r2y_c7 = r2y_c_r[15:8];
   assign r2y_c8 = r2y_c_r[23:16];
   assign r2y_r_offset = r2y_a_r[cccr_pkg::R2Y_OFF_BIT] ?
                         cccr_pkg::OFFSET_16 : 8'd0; // R8
   assign r2y_g_offset = r2y_b_r[cccr_pkg::R2Y_OFF_BIT] ?
                         cccr_pkg::OFFSET_128 : 8'd0; // R10
   assign r2y_b_offset = r2y_c_r[cccr_pkg::R2Y_OFF_BIT] ?
                         cccr_pkg::OFFSET_128 : 8'd0; // R12

endmodule : cccr_regs

// File: tb/cccr_regs_properties.sv
`timescale 1ns/1ps
module cccr_regs_checker #(
   parameter int CMD_LAT = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   input wire logic sensor_vsync,
   input wire logic module_enabled,
   input wire logic codec_capture_active,
   input wire logic [7:0] preview_decim_factor,
   input wire logic preview_decim_active,
   input wire logic [7:0] y2r_y_offset,
   input wire logic [7:0] y2r_cr_offset,
   input wire logic [7:0] y2r_cb_offset,
   input wire logic [7:0] r2y_r_offset,
   input wire logic [7:0] r2y_b_offset
);
   localparam int LAT1 = CMD_LAT + 1;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // -------------------------------------------
   // bus decode, only accepted transfers count
   // -------------------------------------------
   wire acc = psel && penable && clk_en;
   wire wr = acc && pwrite;
   wire rd = acc && !pwrite;
   wire en_wr = wr && paddr == 8'h24 && pwdata[0] && !pwdata[2];
   wire mapped = paddr inside {8'h08, 8'h0C, 8'h10, 8'h14, 8'h18,
                               8'h1C, 8'h20, 8'h24, 8'h28, 8'h5C};
   // en with dis: no drop for 8 cycles
   sequence s_en_dis;
      en_wr && pwdata[1];
   endsequence
   sequence s_no_fall;
      !$fell(module_enabled) [*8];
   endsequence
   // -------------------------------------------
   // properties
   // -------------------------------------------
   AST_PSLVERR: assert property (psel && penable |-> pslverr == !mapped)
      else $error("bad slave error");
   AST_CMD_READ: assert property (rd && paddr == 8'h24 |-> prdata == 32'h0000_0000)
      else $error("command reads nonzero");
   AST_RSVD: assert property (rd && paddr == 8'h0C |-> prdata[31:8] == 24'h00_0000)
      else $error("decim reserved bits set");
   AST_DECIM: assert property ($stable(preview_decim_factor) |->
      preview_decim_active == (preview_decim_factor > 8'h10))
      else $error("decim active wrong");
   AST_Y2R_OFF: assert property (wr && paddr == 8'h14 |=>
      {y2r_y_offset, y2r_cr_offset, y2r_cb_offset} ==
      {$past(pwdata[12]) ? 8'h80 : 8'h00, $past(pwdata[13]) ? 8'h10 :
      8'h00, $past(pwdata[14]) ? 8'h10 : 8'h00})
      else $error("y2r offset wrong");
   AST_R2Y_R: assert property (wr && paddr == 8'h18 |=>
      r2y_r_offset == ($past(pwdata[24]) ? 8'h10 : 8'h00))
      else $error("red offset wrong");
   AST_R2Y_B: assert property (wr && paddr == 8'h20 |=>
      r2y_b_offset == ($past(pwdata[24]) ? 8'h80 : 8'h00))
      else $error("blue offset wrong");
   AST_EN_LAT: assert property ($rose(module_enabled) |-> $past(en_wr, LAT1))
      else $error("enable without command");
   AST_EN_DIS: assert property (s_en_dis |=> s_no_fall)
      else $error("disable not ignored");
   AST_STATE: assert property (rd && paddr == 8'h28 |-> prdata[0] == !module_enabled)
      else $error("state bit wrong");
   AST_CODEC: assert property ($rose(codec_capture_active) |-> $past(sensor_vsync, 2))
      else $error("codec start without vsync");
endmodule : cccr_regs_checker

bind cccr_regs cccr_regs_checker #(.CMD_LAT(CMD_LAT)) u_chk (.*);

// File: tb/cccr_sensor_model.sv
`timescale 1ns/1ps
module cccr_sensor_model #(
   parameter int VS_LEN = 8
) (
   input wire logic pclk,
   input wire logic frame_go,
   output logic sensor_vsync
);
   int cnt_r = 0;
   // one vsync pulse per frame; pin rests low between frames
   always @(posedge pclk) begin
      if (frame_go) begin
         cnt_r <= VS_LEN;
      end else if (cnt_r > 0) begin
         cnt_r <= cnt_r - 1;
      end
   end
   assign sensor_vsync = (cnt_r > 0);
endmodule : cccr_sensor_model

// File: tb/tb.sv
`timescale 1ns/1ps
module tb;
   localparam int LAT = 2;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic clk_en = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic frame_go = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic sensor_vsync;
   logic module_enabled;
   logic codec_capture_active;
   logic preview_decim_active;
   logic [10:0] preview_line_width;
   logic [8:0] y2r_c4;
   logic [7:0] y_off, cr_off, cb_off, r_off, g_off, b_off;
   int errors = 0;
   int samples_checked = 0;
   int cycles = 0;
   logic [7:0] ra [8] = '{8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h5C};
   logic [31:0] rv [8] = '{32'h0000_0000, 32'h0000_0010, 32'h6832_CC95,
      32'h0000_7102, 32'h0132_4145, 32'h0124_5E38, 32'h0138_4A4B, 32'h0000_0000};
   logic [31:0] rm [8] = '{32'h03FF_03FF, 32'h0000_00FF, 32'hFFFF_FFFF,
      32'h0000_71FF, 32'h01FF_FFFF, 32'h01FF_FFFF, 32'h01FF_FFFF, 32'h0000_0001};
   logic [9:0] wh [4] = '{10'h2BC, 10'h2BC, 10'h27F, 10'h27E};
   logic [10:0] ww [4] = '{11'h2BD, 11'h280, 11'h280, 11'h27F};
   logic [7:0] df [4] = '{8'h10, 8'h11, 8'h00, 8'hFF};

   cccr_regs #(.CMD_LAT(LAT)) dut (
      .pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr(), .sensor_vsync, .module_enabled,
      .codec_capture_active, .preview_line_width, .preview_decim_factor(),
      .preview_decim_active, .y2r_c0(), .y2r_c1(), .y2r_c2(), .y2r_c3(),
      .y2r_c4, .y2r_y_offset(y_off), .y2r_cr_offset(cr_off),
      .y2r_cb_offset(cb_off), .r2y_c0(), .r2y_c1(), .r2y_c2(), .r2y_c3(),
      .r2y_c4(), .r2y_c5(), .r2y_c6(), .r2y_c7(), .r2y_c8(),
      .r2y_r_offset(r_off), .r2y_g_offset(g_off), .r2y_b_offset(b_off));
   cccr_sensor_model sensor (.pclk, .frame_go, .sensor_vsync);

   // ---------------------------------
   // bus and check tasks
   // ---------------------------------
   task automatic chk(input string n, logic [31:0] e, logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         errors++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   // setup cycle, then access held until pready seen high at an edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      int n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) chk("pready wait", 32'h0000_0001, 32'h0000_0000);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      apb(1'b1, a, d, q);
   endtask : wr
   task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      apb(1'b0, a, 32'h0000_0000, q);
      chk(n, e, q);
   endtask : rd
   task automatic wait_cmd;
      repeat (LAT + 2) @(posedge pclk);
   endtask : wait_cmd
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : end_sim

   // clock, and a hang guard
   initial forever #4 pclk = ~pclk;
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         errors = errors + 1;
         end_sim();
      end
   end

   // ---------------------------------
   // test sequence
   // ---------------------------------
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd("state after reset", 8'h28, 32'h0000_0001);
      rd("command read", 8'h24, 32'h0000_0000);
      rd("unmapped read", 8'h2C, 32'h0000_0000);
      for (int i = 0; i < 8; i++) begin
         rd("reset value", ra[i], rv[i]);
         wr(ra[i], 32'hFFFF_FFFF);
         rd("writable bits", ra[i], rm[i]);
      end
      repeat (2) @(posedge pclk);
      chk("rgb width", 32'h0000_0280, {21'h0, preview_line_width});
      chk("c4 field", 32'h0000_01FF, {23'h0, y2r_c4});
      chk("y2r offsets", 32'h0080_1010, {8'h0, y_off, cr_off, cb_off});
      chk("r2y offsets", 32'h0010_8080, {8'h0, r_off, g_off, b_off});
      for (int i = 0; i < 8; i++) wr(ra[i], 32'h0000_0000);
      repeat (2) @(posedge pclk);
      chk("offsets off", 32'h0000_0000, {y_off, cr_off, cb_off, r_off});
      chk("g b offsets off", 32'h0000_0000, {16'h0, g_off, b_off});
      for (int i = 0; i < 4; i++) begin
         wr(8'h5C, {31'h0, i > 0});
         wr(8'h08, {6'h0, wh[i], 16'h0});
         wr(8'h0C, {24'h0, df[i]});
         repeat (2) @(posedge pclk);
         chk("line width", {21'h0, ww[i]}, {21'h0, preview_line_width});
         chk("decim active", {31'h0, df[i] > 8'h10}, {31'h0, preview_decim_active});
      end
      $display("test registers finished");
      wr(8'h24, 32'h0000_0001);
      wait_cmd();
      wr(8'h24, 32'h0000_0000);
      rd("enabled", 8'h28, 32'h0000_0000);
      wr(8'h24, 32'h0000_0003);
      wait_cmd();
      rd("enable wins", 8'h28, 32'h0000_0000);
      wr(8'h24, 32'h0000_0002);
      wait_cmd();
      rd("disable done", 8'h28, 32'h0000_0003);
      rd("done cleared", 8'h28, 32'h0000_0001);
      $display("test commands finished");
      wr(8'h24, 32'h0000_0001);
      wait_cmd();
      wr(8'h24, 32'h0000_0100);
      wr(8'h24, 32'h0000_0100);
      rd("codec pending", 8'h28, 32'h0000_0100);
      frame_go <= 1'b1;
      @(posedge pclk);
      frame_go <= 1'b0;
      repeat (12) @(posedge pclk);
      chk("codec active", 32'h0000_0001, {31'h0, codec_capture_active});
      rd("vsync seen", 8'h28, 32'h0000_0400);
      rd("vsync cleared", 8'h28, 32'h0000_0000);
      $display("test codec finished");
      wr(8'h0C, 32'h0000_0055);
      wr(8'h24, 32'h0000_0004);
      wait_cmd();
      rd("reset done", 8'h28, 32'h0000_0005);
      rd("decim restored", 8'h0C, 32'h0000_0010);
      chk("codec stopped", 32'h0000_0000, {31'h0, codec_capture_active});
      clk_en <= 1'b0;
      wr(8'h0C, 32'h0000_0022);
      clk_en <= 1'b1;
      rd("frozen write", 8'h0C, 32'h0000_0010);
      $display("test soft reset finished");
      end_sim();
   end
endmodule : tb
